// file: rtl/refsel_mux.sv
// Reference selection, switchover control and monitor pin multiplexer
// Operation
// RULE1: Toggling codes 0x11-0x14 give first, second, selected, unselected reference clocks.
// RULE2: Differential mode blanks second and unselected taps; first tap carries differential.
// RULE3: Codes 0x15, 0x16 give selected, unselected status active low.
// RULE4: Codes 0x17, 0x18 give first, second frequency status active low.
// RULE5: Code 0x1B gives oscillator status active low.
// RULE6: Codes 0x1D, 0x1E give lock and holdover active low.
// RULE7: Code 0x19 gives AND of first and second frequency status.
// RULE8: Code 0x1A gives AND of lock, selected status and oscillator status.
// RULE9: Code 0x1C is low on second reference, high on first.
// RULE10: Bit 6 picks second reference in manual register control; clear picks first.
// RULE11: Bit 5 set takes manual selection from pin instead of bit 6.
// RULE12: Software enables automatic switchover only while single-ended mode is chosen.
// RULE13: Automatic switchover powers both inputs, ignoring power bits 2 and 1.
// RULE14: Bit 3 clear reverts to first reference once its status is good.
// RULE15: Bit 3 set keeps the second reference, never reverting automatically.
// RULE16: Bit 2 powers the second input, off by default, overridden by automatic.
// RULE17: Bit 0 clear selects single-ended mode, set selects differential mode.
// RULE18: Codes with top bit clear mirror these, active high, selection polarity reversed.
// RULE19: Five-bit select field; all-ones code is reserved and drives low.
// RULE20: Deglitching prevents runt pulses on switching unless bit 7 is set.
module refsel_mux
   import refsel_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ctrl_we_in,
   input wire logic [9:0] ctrl_addr_in,
   input wire logic [7:0] ctrl_wdata_in,
   output logic [7:0] ctrl_rdata_out,
   input wire logic [4:0] monitor_sel_in,
   input wire logic first_reference_input_in,
   input wire logic second_reference_input_in,
   input wire logic differential_reference_input_in,
   input wire logic reference_select_pin_in,
   input wire logic [4:0] status_in,
   output logic reference_monitor_pin_out,
   output logic pll_ref_clk_out,
   output logic using_second_out,
   output logic first_power_out,
   output logic second_power_out
);
   switchover_ctrl_t ctrl_r;
   logic [4:0] sel_r;
   logic using_second_r;
   logic [4:0] status_sync;
   logic pin_sync;
   status_t st;
   taps_t taps;
   logic first_src;
   logic manual_second;
   logic using_second_nxt;
   logic auto_on;
   logic level_hi;
   logic mon_raw;
   logic ctrl_hit;

   refsel_sync #(.WIDTH(6)) u_sync
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in({reference_select_pin_in, status_in}),
      .sync_out({pin_sync, status_sync})
   );

   assign st = status_t'(status_sync);
   assign ctrl_hit = ctrl_we_in && (ctrl_addr_in == SWITCHOVER_CTRL_ADDR);
   assign ctrl_rdata_out = ctrl_r;

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_r <= switchover_ctrl_t'(SWITCHOVER_CTRL_RESET);
         sel_r <= MONITOR_SEL_RESET;
         using_second_r <= 1'b0;
      end
      else
      begin
         if (ctrl_hit)
         begin
            ctrl_r <= switchover_ctrl_t'(ctrl_wdata_in);
         end
         sel_r <= monitor_sel_in;
         using_second_r <= using_second_nxt;
      end
   end

   // RULE17: input mode
   assign first_src = ctrl_r.diff_mode ? differential_reference_input_in
                                       : first_reference_input_in;
   // RULE12: automatic only single-ended
   assign auto_on = ctrl_r.auto_switch & ~ctrl_r.diff_mode;
   // RULE10: register selection
   // RULE11: pin selection
   assign manual_second = ctrl_r.use_select_pin ? pin_sync : ctrl_r.select_second;

   always_comb
   begin
      using_second_nxt = using_second_r;
      if (!auto_on)
      begin
         using_second_nxt = manual_second & ~ctrl_r.diff_mode;
      end
      else if (!using_second_r)
      begin
         using_second_nxt = ~st.first_good;
      end
      // RULE14: revert when good
      // RULE15: stay on second
      else if (!ctrl_r.stay_second && st.first_good)
      begin
         using_second_nxt = 1'b0;
      end
   end
   assign using_second_out = using_second_r;

   // RULE13: auto powers both
   // RULE16: second input power
   assign first_power_out = auto_on | ctrl_r.first_power;
   assign second_power_out = auto_on | ctrl_r.second_power;

   // RULE20: deglitched switch
   refsel_glitchfree u_switch
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .first_clk_in(first_src),
      .second_clk_in(second_reference_input_in),
      .pick_second_in(using_second_r),
      .bypass_in(ctrl_r.deglitch_off),
      .ref_clk_out(pll_ref_clk_out)
   );

   // RULE1: clock taps
   // RULE2: differential blanking
   assign taps.first_clk = first_src;
   assign taps.second_clk = second_reference_input_in & ~ctrl_r.diff_mode;
   assign taps.selected_clk = pll_ref_clk_out;
   assign taps.unselected_clk = ~ctrl_r.diff_mode &
      (using_second_r ? first_reference_input_in : second_reference_input_in);

   function automatic logic status_level(input logic [3:0] code, input status_t s,
                                         input logic sec, input logic diff);
      logic sel_good;
      logic unsel_good;
      sel_good = sec ? s.second_good : s.first_good;
      unsel_good = diff ? 1'b0 : (sec ? s.first_good : s.second_good);
      case (code)
         4'h5: status_level = sel_good;
         4'h6: status_level = unsel_good;
         4'h7: status_level = s.first_good;
         4'h8: status_level = s.second_good;
         4'hB: status_level = s.osc_good;
         4'hC: status_level = sec;
         4'hD: status_level = s.lock;
         4'hE: status_level = s.holdover;
         default: status_level = 1'b0;
      endcase
   endfunction

   assign level_hi = status_level(sel_r[3:0], st, using_second_r, ctrl_r.diff_mode);

   always_comb
   begin
      case (sel_r[3:0])
         4'h0: mon_raw = sel_r[4];
         4'h1: mon_raw = taps.first_clk;
         4'h2: mon_raw = taps.second_clk;
         4'h3: mon_raw = taps.selected_clk;
         4'h4: mon_raw = taps.unselected_clk;
         // RULE7: first AND second
         4'h9: mon_raw = st.first_good & st.second_good;
         // RULE8: lock selected oscillator
         4'hA: mon_raw = st.lock & status_level(4'h5, st, using_second_r, ctrl_r.diff_mode)
                         & st.osc_good;
         // RULE19: reserved code
         4'hF: mon_raw = 1'b0;
         // RULE3: selected unselected low
         // RULE4: frequency status low
         // RULE5: oscillator status low
         // RULE6: lock holdover low
         // RULE9: inverted selection level
         // RULE18: lower codes high
         default: mon_raw = sel_r[4] ? ~level_hi : level_hi;
      endcase
   end

   assign reference_monitor_pin_out = mon_raw;
endmodule // refsel_mux

// file: rtl/refsel_pkg.sv
// Package for the reference select and monitor multiplexer
package refsel_pkg;
   localparam logic [9:0] SWITCHOVER_CTRL_ADDR = 10'h01C;
   localparam int BIT_DEGLITCH_OFF = 7;
   localparam int BIT_SELECT_SECOND = 6;
   localparam int BIT_USE_SELECT_PIN = 5;
   localparam int BIT_AUTO_SWITCH = 4;
   localparam int BIT_STAY_SECOND = 3;
   localparam int BIT_SECOND_POWER = 2;
   localparam int BIT_FIRST_POWER = 1;
   localparam int BIT_DIFF_MODE = 0;
   localparam logic [7:0] SWITCHOVER_CTRL_RESET = 8'h00;
   localparam logic [4:0] MONITOR_SEL_RESET = 5'h00;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic deglitch_off;
      logic select_second;
      logic use_select_pin;
      logic auto_switch;
      logic stay_second;
      logic second_power;
      logic first_power;
      logic diff_mode;
   } switchover_ctrl_t;

   typedef struct packed {
      logic first_good;
      logic second_good;
      logic osc_good;
      logic lock;
      logic holdover;
   } status_t;

   typedef struct packed {
      logic first_clk;
      logic second_clk;
      logic selected_clk;
      logic unselected_clk;
   } taps_t;
endpackage

// file: rtl/refsel_sync.sv
// Two-stage synchroniser for a group of level inputs
module refsel_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // refsel_sync

// file: rtl/refsel_glitchfree.sv
// Glitch-free two-input clock switch, bypassable
module refsel_glitchfree
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic first_clk_in,
   input wire logic second_clk_in,
   input wire logic pick_second_in,
   input wire logic bypass_in,
   output logic ref_clk_out
);
   logic first_en_r;
   logic second_en_r;
   logic first_low;
   logic second_low;
   assign first_low = ~first_clk_in;
   assign second_low = ~second_clk_in;

   // Enable one side only after the other has closed
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         first_en_r <= 1'b1;
         second_en_r <= 1'b0;
      end
      else
      begin
         first_en_r <= first_low ? (~pick_second_in & ~second_en_r) : first_en_r;
         second_en_r <= second_low ? (pick_second_in & ~first_en_r) : second_en_r;
      end
   end

   assign ref_clk_out = bypass_in ? (pick_second_in ? second_clk_in : first_clk_in)
                                  : ((first_clk_in & first_en_r) | (second_clk_in & second_en_r));
endmodule // refsel_glitchfree

// file: tb/refsel_mux_monitor.sv
// Assertion checker for the reference select block
module refsel_monitor
   import refsel_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ctrl_we_in,
   input wire logic [9:0] ctrl_addr_in,
   input wire logic [7:0] ctrl_wdata_in,
   input wire logic [7:0] ctrl_rdata_out,
   input wire logic [4:0] monitor_sel_in,
   input wire logic first_reference_input_in,
   input wire logic second_reference_input_in,
   input wire logic differential_reference_input_in,
   input wire logic reference_select_pin_in,
   input wire logic [4:0] status_in,
   input wire logic reference_monitor_pin_out,
   input wire logic pll_ref_clk_out,
   input wire logic using_second_out,
   input wire logic first_power_out,
   input wire logic second_power_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [7:0] c = ctrl_rdata_out;
   wire [4:0] m = monitor_sel_in;
   wire p = reference_monitor_pin_out;
   wire u = using_second_out;
   wire [18:0] snap = {m, status_in, c, reference_select_pin_in};
   wire man = !c[4] || c[0];
   wire wr = ctrl_we_in && ctrl_addr_in == SWITCHOVER_CTRL_ADDR;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence calm; $stable(snap)[*7]; endsequence
   a_write_shown: assert property (wr |=> c == $past(ctrl_wdata_in))
      else $error("write not shown");
   a_auto_power: assert property (calm ##0 !man |-> first_power_out && second_power_out)
      else $error("auto power off");
   a_manual_power: assert property (calm ##0 !c[4] |-> second_power_out == c[2])
      else $error("second power wrong");
   a_reg_select: assert property (calm ##0 (man && !c[5]) |-> u == (c[6] && !c[0]))
      else $error("register select wrong");
   a_auto_revert: assert property (calm ##0 (!man && !c[3]) |-> u == !status_in[4])
      else $error("revert wrong");
   a_stay_second: assert property (!man && c[3] && u && $stable(c) |=> u)
      else $error("left second");
   a_sel_level: assert property (calm ##0 m == 5'h1C |-> p == !u)
      else $error("select level wrong");
   a_osc_low: assert property (calm ##0 m == 5'h1B |-> p == !status_in[2])
      else $error("osc level wrong");
   a_reserved_low: assert property (calm ##0 m == 5'h1F |-> !p)
      else $error("reserved not low");
   a_diff_blank: assert property (calm ##0 (c[0] && m[3:0] inside {4'h2, 4'h4}) |-> !p)
      else $error("differential tap not blank");
   a_freq_and: assert property (calm ##0 m[3:0] == 4'h9 |-> p == (status_in[4] && status_in[3]))
      else $error("frequency and wrong");
endmodule // refsel_monitor
bind refsel_mux refsel_monitor u_mon (.*);

// file: tb/refsrc_model.sv
// Reference clock sources and board status model
module refsrc_model
(
   input wire logic [4:0] want_status_in,
   input wire logic want_pin_in,
   output logic first_clk_out,
   output logic second_clk_out,
   output logic diff_clk_out,
   output logic [4:0] status_out,
   output logic select_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {first_clk_out, second_clk_out, diff_clk_out} = 3'h0;
   // Free-running sources kept off the core clock edges
   always #7.013 first_clk_out = ~first_clk_out;
   always #11.017 second_clk_out = ~second_clk_out;
   always #9.011 diff_clk_out = ~diff_clk_out;
   assign status_out = want_status_in;
   assign select_pin_out = want_pin_in;
endmodule // refsrc_model

// file: tb/tb_top.sv
// Self-checking bench for the reference select block
module tb_top
   import refsel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] AT = SWITCHOVER_CTRL_ADDR;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ctrl_we_in = 1'b0;
   logic [9:0] ctrl_addr_in = '0;
   logic [7:0] ctrl_wdata_in = '0;
   logic [4:0] monitor_sel_in = '0;
   logic [4:0] st = 5'h1F;
   logic pin_w = 1'b0;
   logic [7:0] ctrl = SWITCHOVER_CTRL_RESET;
   logic sec_e = 1'b0;
   logic [7:0] ctrl_rdata_out;
   logic [4:0] status_in;
   logic f, s, d, reference_select_pin_in, reference_monitor_pin_out, pll_ref_clk_out;
   logic using_second_out, first_power_out, second_power_out;
   int miscompares = 0;
   int samples_checked = 0;
   logic [11:0] exp_q[$];
   event obs_ev;
   always #2.5 core_clk_in = ~core_clk_in;
   refsel_mux u_dut
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ctrl_we_in(ctrl_we_in),
      .ctrl_addr_in(ctrl_addr_in),
      .ctrl_wdata_in(ctrl_wdata_in),
      .ctrl_rdata_out(ctrl_rdata_out),
      .monitor_sel_in(monitor_sel_in),
      .first_reference_input_in(f),
      .second_reference_input_in(s),
      .differential_reference_input_in(d),
      .reference_select_pin_in(reference_select_pin_in),
      .status_in(status_in),
      .reference_monitor_pin_out(reference_monitor_pin_out),
      .pll_ref_clk_out(pll_ref_clk_out),
      .using_second_out(using_second_out),
      .first_power_out(first_power_out),
      .second_power_out(second_power_out)
   );
   refsrc_model u_src (.want_status_in(st), .want_pin_in(pin_w), .first_clk_out(f),
      .second_clk_out(s), .diff_clk_out(d), .status_out(status_in),
      .select_pin_out(reference_select_pin_in));
   function automatic logic exp_pin(input logic [4:0] c);
      logic v;
      case (c[3:0])
         4'h0: v = c[4];
         4'h1: v = ctrl[0] ? d : f;
         4'h2: v = !ctrl[0] && s;
         4'h3: v = ctrl[0] ? d : (sec_e ? s : f);
         4'h4: v = !ctrl[0] && (sec_e ? f : s);
         4'h5: v = sec_e ? st[3] : st[4];
         4'h6: v = !ctrl[0] && (sec_e ? st[4] : st[3]);
         4'h7: v = st[4];
         4'h8: v = st[3];
         4'h9: v = st[4] & st[3];
         4'hA: v = st[1] & st[2] & (sec_e ? st[3] : st[4]);
         4'hB: v = st[2];
         4'hC: v = sec_e;
         4'hD: v = st[1];
         4'hE: v = st[0];
         default: v = 1'b0;
      endcase
      return (c[4] && c[3:0] inside {[5:8], [11:14]}) ? !v : v;
   endfunction
   task automatic check(input logic [11:0] seen, input logic [11:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("[FAIL] outputs expected %h seen %h", want, seen);
      end
   endtask
   always @(obs_ev) check({ctrl_rdata_out, using_second_out, first_power_out,
      second_power_out, reference_monitor_pin_out}, exp_q.pop_front());
   task automatic note();
      exp_q.push_back({ctrl, sec_e, (ctrl[4] & !ctrl[0]) | ctrl[1], (ctrl[4] & !ctrl[0]) | ctrl[2],
         exp_pin(monitor_sel_in)});
      -> obs_ev;
   endtask
   task automatic step(input logic [4:0] sv, input logic se);
      st = sv;
      repeat (10) @(negedge core_clk_in);
      sec_e = se;
      note();
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] val);
      @(negedge core_clk_in);
      ctrl_we_in = 1'b1;
      ctrl_addr_in = a;
      ctrl_wdata_in = val;
      @(negedge core_clk_in);
      ctrl_we_in = 1'b0;
      if (a == AT) ctrl = val;
   endtask
   task automatic sweep();
      for (int i = 0; i < 32; i++)
      begin
         monitor_sel_in = i[4:0];
         step(5'($urandom), sec_e);
      end
   endtask
   task automatic conclude();
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h8D55908F));
      repeat (4) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_in = 1'b0;
      note();
      wr(10'h01D, 8'hFF);
      step(st, 1'b0);
      sweep();
      wr(AT, 8'h46);
      step(st, 1'b1);
      sweep();
      monitor_sel_in = 5'h03;
      wr(AT, 8'hC6);
      step(st, 1'b1);
      wr(AT, 8'h60);
      step(st, 1'b0);
      pin_w = 1'b1;
      step(st, 1'b1);
      st = 5'h1F;
      wr(AT, 8'h10);
      step(5'h1F, 1'b0);
      step(5'h0F, 1'b1);
      step(5'h1F, 1'b0);
      wr(AT, 8'h18);
      step(5'h0F, 1'b1);
      step(5'h1F, 1'b1);
      @(negedge core_clk_in);
      rst_in = 1'b1;
      monitor_sel_in = 5'h00;
      repeat (2) @(negedge core_clk_in);
      rst_in = 1'b0;
      ctrl = SWITCHOVER_CTRL_RESET;
      sec_e = 1'b0;
      note();
      wr(AT, 8'h01);
      step(st, 1'b0);
      sweep();
      conclude();
   end
   initial
   begin
      #100000;
      miscompares++;
      conclude();
   end
endmodule // tb_top
